// ---- design/cae_channel_alarm.sv ----
// channel alarm evaluator: bias, four alarm levels, ahb-lite registers
`timescale 1ns/1ps

// Function
// - add range-limited signed bias to input
// - bias ignored for discrete on/off range
// - flag burnout unreliable at 1-20 ms scan on high-speed module
// - four levels, each off by default
// - each level takes one of ten types
// - high alarm at or above value
// - low alarm at or below value
// - rising change over interval reaches magnitude
// - falling change over interval reaches magnitude
// - delayed high after continuous hold period
// - delayed low after continuous hold period
// - difference high at or above value
// - difference low; difference types need delta
// - profile types compare loaded upper/lower limits
// - no profile with log; no value/hysteresis
// - hysteresis only H,L,h,l; scaled max 100000
// - value default zero; current-input hysteresis 0.05
// - limit values within measurable range
// - rate values one digit to range width
// - destination off/relay/switch, number when not off
// - relay only if alarm relay exists
// - switch only if alarm switch exists
// - high clears below value minus hysteresis
// - rate interval equals scan times samples
// - logging off still drives outputs
module cae_channel_alarm (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // scan stream and alarm results
  input  wire cae_pkg::cae_scan_t scan_i,
  output cae_pkg::cae_alarm_t     alarm_o
);
  import cae_pkg::*;

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  logic       wr_q;    // write data phase pending
  logic [7:0] addr_q;  // latched address byte
  wire        acc = hsel & htrans[1] & hready;  // word accesses only in this map

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= acc & hwrite;
      if (acc) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay

  // ---------------------------------------------------------------
  // channel registers
  // ---------------------------------------------------------------
  logic [31:0]        ctrl_q;          // control word
  logic signed [31:0] bias_q;          // bias
  logic signed [31:0] rlo_q, rhi_q;    // measurable range
  logic [31:0]        cfg_q  [NLVL];   // level configs
  logic signed [31:0] val_q  [NLVL];   // alarm values
  logic signed [31:0] hyst_q [NLVL];   // hysteresis
  logic [31:0]        dly_q  [NLVL];   // delay seconds

  // decoded control fields
  wire        disc    = ctrl_q[CTL_DISC];
  wire  cae_calc_t calc = cae_calc_t'(ctrl_q[CTL_CALC +: 3]);
  wire        relav   = ctrl_q[CTL_RELAV];
  wire        swav    = ctrl_q[CTL_SWAV];
  wire [3:0]  nsamp   = ctrl_q[CTL_NS +: 4];
  wire [15:0] scan_ms = ctrl_q[CTL_SCAN +: 16];
  wire        is_log  = (calc == C_LOG) | (calc == C_PLOG) | (calc == C_LOGLIN);
  wire        scaled  = (calc == C_LIN) | (calc == C_SQRT);
  wire signed [31:0] width = rhi_q - rlo_q;  // measurable span
  wire signed [31:0] wdat  = hwdata;

  // write decode
  wire ctrl_we = wr_q & (addr_q == OFS_CTRL);
  wire bias_we = wr_q & (addr_q == OFS_BIAS);
  wire rlo_we  = wr_q & (addr_q == OFS_RANGE_LO);
  wire rhi_we  = wr_q & (addr_q == OFS_RANGE_HI);
  wire lvl_we  = wr_q & (addr_q[7:6] == LVL_BASE_HI);
  wire [1:0] lvl_ix  = addr_q[5:4];
  wire [1:0] lvl_sub = addr_q[3:2];
  // current-input set: reload the documented level defaults
  wire cur_load = ctrl_we & hwdata[CTL_CUR] & ~ctrl_q[CTL_CUR];

  // bias limited to its range, discrete channels refuse it
  wire bias_ok = ~disc & (wdat <= BIAS_MAX) & (wdat >= -BIAS_MAX);

  // level config acceptance
  wire cae_type_t w_type = cae_type_t'(hwdata[CFG_TYPE +: 4]);
  wire cae_dst_t  w_dst  = cae_dst_t'(hwdata[CFG_DST +: 2]);
  wire w_dif  = (w_type == T_DIF_HI) | (w_type == T_DIF_LO);
  wire w_prf  = (w_type == T_PRF_HI) | (w_type == T_PRF_LO);
  wire type_ok = (hwdata[CFG_TYPE +: 4] <= 4'h9)
               & ~(w_dif & (calc != C_DELTA))
               & ~(w_prf & is_log);
  wire dst_ok  = (w_dst == D_OFF)
               | ((w_dst == D_RELAY) & relav)
               | ((w_dst == D_SWITCH) & swav);
  wire cfg_ok  = type_ok & dst_ok;

  // per-level type of the addressed level
  wire cae_type_t a_type = cae_type_t'(cfg_q[lvl_ix][CFG_TYPE +: 4]);
  wire a_lim = (a_type == T_HIGH) | (a_type == T_LOW)
             | (a_type == T_DLY_HI) | (a_type == T_DLY_LO);
  wire a_roc = (a_type == T_ROC_HI) | (a_type == T_ROC_LO);
  wire a_dif = (a_type == T_DIF_HI) | (a_type == T_DIF_LO);
  // value acceptance by type; profile levels take no value
  wire val_ok = (a_lim & (wdat >= rlo_q) & (wdat <= rhi_q))
              | (a_roc & (wdat >= 32'sd1) & (wdat <= width))
              | a_dif;
  // hysteresis only for plain and difference limits
  wire hyst_ok = (a_type == T_HIGH | a_type == T_LOW | a_dif)
               & (wdat >= 32'sd0)
               & (wdat <= (scaled ? HYST_MAX : width));

  // channel-wide registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
      bias_q <= '0;
      rlo_q  <= '0;
      rhi_q  <= '0;
    end else begin
      if (ctrl_we) ctrl_q <= hwdata;
      if (disc | (ctrl_we & hwdata[CTL_DISC])) begin
        bias_q <= '0;
      end else if (bias_we & bias_ok) begin
        bias_q <= wdat;
      end
      if (rlo_we) rlo_q <= wdat;
      if (rhi_we) rhi_q <= wdat;
    end
  end

  // ---------------------------------------------------------------
  // scan capture: bias applied before any level sees the value
  // ---------------------------------------------------------------
  logic               ev_q;      // corrected sample ready
  logic signed [31:0] corr_q;    // bias-corrected value
  logic signed [31:0] ref_q;     // reference channel
  logic signed [31:0] phi_q;     // profile upper
  logic signed [31:0] plo_q;     // profile lower

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_q   <= 1'b0;
      corr_q <= '0;
      ref_q  <= '0;
      phi_q  <= '0;
      plo_q  <= '0;
    end else begin
      ev_q <= scan_i.valid;
      if (scan_i.valid) begin
        corr_q <= scan_i.value + (disc ? 32'sd0 : bias_q);
        ref_q  <= scan_i.ref_value;
        phi_q  <= scan_i.prof_hi;
        plo_q  <= scan_i.prof_lo;
      end
    end
  end

  // ---------------------------------------------------------------
  // rate history: the interval is the sample count times the scan
  // ---------------------------------------------------------------
  logic signed [31:0] hist_mem [HIST];  // past corrected values
  logic [3:0]         wp_q;             // next write slot
  logic [4:0]         fill_q;           // samples held, saturating
  wire  [3:0]         past_ix = wp_q - nsamp;
  wire signed [31:0]  past    = hist_mem[past_ix];
  wire                roc_rdy = (nsamp != 4'h0) & (fill_q >= {1'b0, nsamp});
  wire signed [32:0]  rise    = {corr_q[31], corr_q} - {past[31], past};
  wire signed [32:0]  diff    = {corr_q[31], corr_q} - {ref_q[31], ref_q};

  // history write, no reset needed on the data array
  always_ff @(posedge hclk) begin
    if (ev_q) hist_mem[wp_q] <= corr_q;
  end

  // history pointers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q   <= 4'h0;
      fill_q <= 5'h00;
    end else if (ev_q) begin
      wp_q <= wp_q + 4'h1;
      if (fill_q != 5'h10) fill_q <= fill_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // alarm levels
  // ---------------------------------------------------------------
  logic [NLVL-1:0] act_q;   // alarm states
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  genvar gi;
  generate
    for (gi = 0; gi < NLVL; gi++) begin : g_lvl
      logic [31:0] elap_q;  // ms the delayed condition has held
      wire en = cfg_q[gi][CFG_EN];
      wire cae_type_t ty = cae_type_t'(cfg_q[gi][CFG_TYPE +: 4]);
      wire signed [32:0] v  = {val_q[gi][31], val_q[gi]};
      // discrete channels have fixed zero hysteresis
      wire signed [32:0] h  = disc ? 33'sd0 : {hyst_q[gi][31], hyst_q[gi]};
      wire signed [32:0] c  = {corr_q[31], corr_q};
      wire we_l = lvl_we & (lvl_ix == 2'(gi));
      wire dly_cond = (ty == T_DLY_HI) ? (c >= v) : (c <= v);
      // only delay types keep time, so a retyped level starts from zero
      wire dly_ty   = (ty == T_DLY_HI) | (ty == T_DLY_LO);
      wire [31:0] elap_n = elap_q + {16'h0000, scan_ms};
      wire dly_met = dly_cond & (elap_n >= dly_q[gi] * MS_PER_S);
      logic cond;  // next alarm state for this scan

      // level condition per alarm type
      always_comb begin
        cond = 1'b0;
        unique case (ty)
          T_HIGH:   cond = act_q[gi] ? (c >= v - h) : (c >= v);
          T_LOW:    cond = act_q[gi] ? (c <= v + h) : (c <= v);
          T_ROC_HI: cond = roc_rdy & (rise >= v);
          T_ROC_LO: cond = roc_rdy & (-rise >= v);
          T_DLY_HI: cond = dly_met;
          T_DLY_LO: cond = dly_met;
          T_DIF_HI: cond = act_q[gi] ? (diff >= v - h) : (diff >= v);
          T_DIF_LO: cond = act_q[gi] ? (diff <= v + h) : (diff <= v);
          T_PRF_HI: cond = corr_q >= phi_q;
          T_PRF_LO: cond = corr_q <= plo_q;
          default:  cond = 1'b0;  // unused codes are refused at write
        endcase
      end

      // level registers and state
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg_q[gi]  <= CFG_RST;
          val_q[gi]  <= VAL_RST;
          hyst_q[gi] <= HYST_RST;
          dly_q[gi]  <= DLY_RST;
          act_q[gi]  <= 1'b0;
          elap_q     <= '0;
        end else begin
          if (we_l & (lvl_sub == SUB_CFG) & cfg_ok) cfg_q[gi] <= hwdata;
          if (cur_load) begin
            val_q[gi]  <= VAL_RST;
            hyst_q[gi] <= HYST_CUR_DEF;
          end else begin
            if (we_l & (lvl_sub == SUB_VAL) & val_ok) val_q[gi] <= wdat;
            if (we_l & (lvl_sub == SUB_HYST) & hyst_ok) hyst_q[gi] <= wdat;
          end
          if (we_l & (lvl_sub == SUB_DLY)) dly_q[gi] <= hwdata;
          // once per scan, on the corrected value of that scan
          if (!en) begin
            act_q[gi] <= 1'b0;
            elap_q    <= '0;
          end else if (ev_q) begin
            act_q[gi] <= cond;
            elap_q    <= (dly_cond & dly_ty) ? elap_n : 32'h0000_0000;
          end
        end
      end

      // assertions tied to this level
      a_dis_quiet: assert property (!en |=> !act_q[gi])
        else $error("disabled level raised an alarm");
      a_high_sets: assert property (en & ev_q & (ty == T_HIGH) & (c >= v) ##1 en
        |-> act_q[gi])
        else $error("high limit not raised");
      a_low_sets: assert property (en & ev_q & (ty == T_LOW) & (c <= v) ##1 en
        |-> act_q[gi])
        else $error("low limit not raised");
      a_high_holds: assert property (en & act_q[gi] & ev_q & (ty == T_HIGH)
        & (c >= v - h) ##1 en |-> act_q[gi])
        else $error("high alarm released inside hysteresis");
      a_roc_rise: assert property (en & ev_q & (ty == T_ROC_HI) & roc_rdy
        & (rise >= v) ##1 en |-> act_q[gi])
        else $error("rate rise not raised");
      a_delay_wait: assert property (en & ev_q & (ty == T_DLY_HI) & (c < v)
        ##1 en |-> !act_q[gi] && elap_q == 0)
        else $error("delayed high raised without hold");
    end
  endgenerate

  // ---------------------------------------------------------------
  // output routing and status
  // ---------------------------------------------------------------
  logic [NOUT-1:0] relay_d, isw_d;  // ored destinations

  // route each active level to its numbered output, logging aside
  always_comb begin
    relay_d = '0;
    isw_d   = '0;
    for (int i = 0; i < NLVL; i++) begin
      if (act_q[i] & (cfg_q[i][CFG_DST +: 2] == D_RELAY)) begin
        relay_d[cfg_q[i][CFG_NUM +: 4]] = 1'b1;
      end
      if (act_q[i] & (cfg_q[i][CFG_DST +: 2] == D_SWITCH)) begin
        isw_d[cfg_q[i][CFG_NUM +: 4]] = 1'b1;
      end
    end
  end

  logic [NLVL-1:0] log_en;  // per-level logging bits
  for (genvar li = 0; li < NLVL; li++) begin : g_log
    assign log_en[li] = cfg_q[li][CFG_LOG];
  end

  // registered alarm outputs, one cycle behind the level state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_o <= '0;
    end else begin
      alarm_o.active <= act_q;
      alarm_o.logged <= act_q & log_en;
      alarm_o.relay  <= relay_d;
      alarm_o.isw    <= isw_d;
    end
  end

  // burnout detection is not trustworthy on fast scans
  wire burn_unrel = ctrl_q[CTL_HS]
                  & (scan_ms >= BURN_LO_MS) & (scan_ms <= BURN_HI_MS);

  // read mux from the latched address
  wire [31:0] status_w = {26'h0, roc_rdy, burn_unrel, act_q};
  wire [31:0] lvl_rd   = (lvl_sub == SUB_CFG)  ? cfg_q[lvl_ix]  :
                         (lvl_sub == SUB_VAL)  ? val_q[lvl_ix]  :
                         (lvl_sub == SUB_HYST) ? hyst_q[lvl_ix] : dly_q[lvl_ix];
  assign hrdata = (addr_q == OFS_CTRL)     ? ctrl_q   :
                  (addr_q == OFS_BIAS)     ? bias_q   :
                  (addr_q == OFS_RANGE_LO) ? rlo_q    :
                  (addr_q == OFS_RANGE_HI) ? rhi_q    :
                  (addr_q == OFS_STATUS)   ? status_w :
                  (addr_q == OFS_CORR)     ? corr_q   :
                  (addr_q[7:6] == LVL_BASE_HI) ? lvl_rd : 32'h0000_0000;

  // ---------------------------------------------------------------
  // channel-level assertions
  // ---------------------------------------------------------------
  sequence s_scan_in;
    scan_i.valid & ~disc & ~ctrl_we;
  endsequence
  sequence s_bad_relay;
    wr_q & lvl_we & (lvl_sub == SUB_CFG) & (w_dst == D_RELAY) & ~relav;
  endsequence

  a_bias_add: assert property (s_scan_in |=> corr_q == $past(scan_i.value)
    + $past(bias_q))
    else $error("bias not added to sample");
  a_bias_disc: assert property (scan_i.valid & disc |=> corr_q == $past(scan_i.value))
    else $error("bias applied on discrete range");
  a_relay_refuse: assert property (s_bad_relay |=> cfg_q[$past(lvl_ix)]
    == $past(cfg_q[lvl_ix]))
    else $error("relay destination taken without alarm relay");
  a_log_free: assert property (ev_q ##1 1 ##1 1 |-> alarm_o.active == $past(act_q))
    else $error("alarm output not following state");

endmodule

// ---- design/cae_pkg.sv ----
// shared constants and types for the channel alarm evaluator
package cae_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, low address byte only)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;  // channel control
  localparam logic [7:0] OFS_BIAS     = 8'h04;  // signed bias
  localparam logic [7:0] OFS_RANGE_LO = 8'h08;  // measurable range low end
  localparam logic [7:0] OFS_RANGE_HI = 8'h0C;  // measurable range high end
  localparam logic [7:0] OFS_STATUS   = 8'h10;  // live alarm state, read only
  localparam logic [7:0] OFS_CORR     = 8'h14;  // last corrected value, read only
  localparam logic [1:0] LVL_BASE_HI  = 2'h1;   // addr[7:6] for level block 0x40..0x7f
  localparam logic [1:0] SUB_CFG      = 2'h0;   // +0x0 level config
  localparam logic [1:0] SUB_VAL      = 2'h1;   // +0x4 alarm value
  localparam logic [1:0] SUB_HYST     = 2'h2;   // +0x8 hysteresis
  localparam logic [1:0] SUB_DLY      = 2'h3;   // +0xc delay in seconds

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_DISC  = 0;   // discrete on/off range
  localparam int CTL_CALC  = 1;   // 3-bit calculation mode
  localparam int CTL_CUR   = 4;   // current-input channel
  localparam int CTL_HS    = 5;   // high-speed module
  localparam int CTL_RELAV = 6;   // a relay output is typed alarm
  localparam int CTL_SWAV  = 7;   // an internal switch is typed alarm
  localparam int CTL_NS    = 8;   // 4-bit rate sample count
  localparam int CTL_SCAN  = 16;  // 16-bit scan interval in ms
  localparam int CFG_EN    = 0;   // level on
  localparam int CFG_TYPE  = 1;   // 4-bit alarm type
  localparam int CFG_LOG   = 5;   // logging on
  localparam int CFG_DST   = 6;   // 2-bit destination
  localparam int CFG_NUM   = 8;   // 4-bit output number

  // ---------------------------------------------------------------
  // reset values, limits and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST     = 32'h0001_0100; // 1 ms scan, 1 sample
  localparam logic [31:0] CFG_RST      = 32'h0000_0020; // off, logging on
  localparam logic [31:0] VAL_RST      = 32'h0000_0000;
  localparam logic [31:0] HYST_RST     = 32'h0000_0000;
  localparam logic [31:0] DLY_RST      = 32'h0000_000A; // 10 s
  localparam logic [31:0] HYST_CUR_DEF = 32'h0000_0005; // 0.05 in hundredths
  localparam logic signed [31:0] BIAS_MAX = 32'sd999999;
  localparam logic signed [31:0] HYST_MAX = 32'sd100000;
  localparam logic [15:0] BURN_LO_MS   = 16'h0001;
  localparam logic [15:0] BURN_HI_MS   = 16'h0014;     // 20 ms
  localparam logic [31:0] MS_PER_S     = 32'h0000_03E8; // 1000
  localparam int NLVL = 4;
  localparam int NOUT = 16;
  localparam int HIST = 16;

  // ---------------------------------------------------------------
  // enumerations and carriers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    T_HIGH, T_LOW, T_ROC_HI, T_ROC_LO, T_DLY_HI, T_DLY_LO,
    T_DIF_HI, T_DIF_LO, T_PRF_HI, T_PRF_LO
  } cae_type_t;
  typedef enum logic [2:0] {
    C_OFF, C_LIN, C_SQRT, C_DELTA, C_LOG, C_PLOG, C_LOGLIN
  } cae_calc_t;
  typedef enum logic [1:0] {D_OFF, D_RELAY, D_SWITCH} cae_dst_t;

  typedef struct packed {
    logic               valid;     // one-cycle pulse per scan
    logic signed [31:0] value;     // raw or linear-scaled input
    logic signed [31:0] ref_value; // reference channel for difference
    logic signed [31:0] prof_hi;   // loaded profile upper limit
    logic signed [31:0] prof_lo;   // loaded profile lower limit
  } cae_scan_t;

  typedef struct packed {
    logic [NLVL-1:0] active;  // level alarm states
    logic [NLVL-1:0] logged;  // active and logging on
    logic [NOUT-1:0] relay;   // relay drives
    logic [NOUT-1:0] isw;     // internal switch drives
  } cae_alarm_t;

endpackage

// ---- dv/tb.sv ----
// self-checking testbench for the channel alarm evaluator
`timescale 1ns/1ps
module tb;
  import cae_pkg::*;
  // ---------------------------------------------------------------
  // stimulus, observed outputs and bookkeeping
  // ---------------------------------------------------------------
  logic            hclk = 1'b0;
  logic            hresetn = 1'b0;
  logic            hsel = 1'b0;
  logic            hwrite = 1'b0;
  logic [1:0]      htrans = 2'b00;
  logic [31:0]     haddr = 32'h0000_0000;
  logic [31:0]     hwdata = 32'h0000_0000;
  logic [31:0]     hrdata;
  logic            hreadyout;
  logic            hresp;
  cae_scan_t       scan_i = '0;
  cae_alarm_t      alarm_o;
  logic            rd_dp = 1'b0;  // a read data phase is open
  logic            al_dp = 1'b0;  // alarm outputs due this cycle
  logic [31:0]     exp_q[$];      // expectations in issue order
  int              err_count = 0;
  int              n_compared = 0;
  logic signed [31:0] v;

  always #2 hclk = ~hclk;  // 250 MHz

  // hready is looped back as the only slave on the bus
  cae_channel_alarm u_cae_channel_alarm (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scan_i(scan_i), .alarm_o(alarm_o));

  // ---------------------------------------------------------------
  // comparison, verdict and watchdog
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // a stuck handshake would otherwise run forever
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end

  // oldest note is matched with each result as it shows
  always @(posedge hclk) begin
    if (rd_dp) check(hrdata, exp_q.pop_front());
    if (al_dp) check({8'h00, alarm_o.isw[7:0], alarm_o.relay[7:0], alarm_o.logged,
                      alarm_o.active}, exp_q.pop_front());
  end

  // ---------------------------------------------------------------
  // bus and scan drivers; each is entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= ~w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // result shows two edges after the valid edge
  task automatic scan(input logic signed [31:0] val, input logic [31:0] e);
    scan_i <= '{1'b1, val, $urandom, $urandom, $urandom};
    @(posedge hclk);
    scan_i.valid <= 1'b0;
    repeat (2) @(posedge hclk);
    exp_q.push_back(e);
    al_dp <= 1'b1;
    @(posedge hclk);
    al_dp <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(2297));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_CTRL, CTRL_RST);
    rd(8'h40, CFG_RST);
    rd(8'h44, VAL_RST);
    rd(8'h4C, DLY_RST);
    rd(8'h20, 32'h0000_0000);
    $display("test reset values done");
    // linear calc, relay and switch available, one sample, 1 ms scan
    bus(1'b1, OFS_CTRL, 32'h0001_01C2);
    bus(1'b1, OFS_RANGE_LO, 32'hFFFF_FC18);
    bus(1'b1, OFS_RANGE_HI, 32'h0000_03E8);
    bus(1'b1, OFS_BIAS, 32'h0000_0007);
    bus(1'b1, OFS_BIAS, 32'h000F_4240);  // one past the top, kept out
    rd(OFS_BIAS, 32'h0000_0007);
    v = 32'($urandom_range(50, 0));
    scan(v, 32'h0000_0000);
    rd(OFS_CORR, v + 32'sd7);
    $display("test bias done");
    bus(1'b1, 8'h40, 32'h0000_0361);  // high, logging, relay 3
    bus(1'b1, 8'h44, 32'h0000_0064);
    bus(1'b1, 8'h48, 32'h0000_000A);
    bus(1'b1, 8'h50, 32'h0000_0583);  // low, no logging, switch 5
    bus(1'b1, 8'h54, 32'hFFFF_FF9C);
    scan(32'sd93, 32'h0000_0811);
    scan(32'sd88, 32'h0000_0811);
    scan(32'sd82, 32'h0000_0000);
    scan(-32'sd107, 32'h0020_0002);
    rd(OFS_STATUS, 32'h0000_0022);
    $display("test limits done");
    bus(1'b1, 8'h40, 32'h0000_000D);  // difference type without delta
    rd(8'h40, 32'h0000_0361);
    bus(1'b1, 8'h50, 32'h0000_0582);
    scan(-32'sd107, 32'h0000_0000);
    // level 2 as rising rate, one sample back, magnitude 20
    bus(1'b1, 8'h60, 32'h0000_0025);
    bus(1'b1, 8'h64, 32'h0000_0014);
    scan(-32'sd80, 32'h0000_0044);
    scan(-32'sd80, 32'h0000_0000);
    $display("test rate done");
    // 500 ms scan, level 2 as delayed high at 50 held for 1 s
    bus(1'b1, OFS_CTRL, 32'h01F4_01C2);
    bus(1'b1, 8'h60, 32'h0000_0029);
    bus(1'b1, 8'h64, 32'h0000_0032);
    bus(1'b1, 8'h6C, 32'h0000_0001);
    scan(32'sd60, 32'h0000_0000);
    scan(32'sd60, 32'h0000_0044);
    scan(-32'sd80, 32'h0000_0000);
    $display("test delay done");
    // current input on a fast module with a 20 ms scan
    bus(1'b1, OFS_CTRL, 32'h0014_01F2);
    rd(OFS_STATUS, 32'h0000_0030);
    rd(8'h44, VAL_RST);
    rd(8'h48, HYST_CUR_DEF);
    $display("test current input done");
    bus(1'b1, OFS_CTRL, 32'h0001_01C3);
    rd(OFS_BIAS, 32'h0000_0000);
    $display("test refusals done");
    // let the last data phase be checked, then no note may be left over
    @(posedge hclk);
    check(exp_q.size(), 32'h0000_0000);
    tally_and_finish();
  end
endmodule
